/* shared/tblsc_pkg.sv */
// Constants, register map and types of the two-bit level slicer control.
// Assumes a 40 MHz reference clock and an AXI4-Lite master with 32-bit data.
package tblsc_pkg;

  // ****************************************************************
  // Bus
  // ****************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int          ST_PEAK_LSB   = 0;
  localparam int          ST_VALLEY_LSB = 8;
  localparam int          ST_MODE_LSB   = 16;
  localparam int          ST_INH_BIT    = 18;
  localparam int          ST_WIDE_BIT   = 19;
  localparam int          ST_SUPPLY_BIT = 20;
  localparam int          ST_CODE_LSB   = 22;
  localparam int          ST_OVF_BIT    = 24;

  // ****************************************************************
  // Tracking
  // ****************************************************************
  localparam int          LVL_W        = 8;
  localparam logic [7:0]  LEVEL_RESET  = 8'h80;
  localparam logic [7:0]  STEP_FAST    = 8'h04;
  localparam logic [7:0]  STEP_SLOW    = 8'h01;
  localparam logic [5:0]  DECAY_FAST   = 6'h0F;
  localparam logic [5:0]  DECAY_SLOW   = 6'h3F;
  localparam logic [10:0] HI_NUM       = 11'h005;
  localparam logic [10:0] SIXTH_DEN    = 11'h006;

  // ****************************************************************
  // Output codes {bit1, bit0}, Gray order from lowest to highest
  // ****************************************************************
  localparam int          CODE_W       = 2;
  localparam logic [1:0]  CODE_LOWEST  = 2'h0;
  localparam logic [1:0]  CODE_LOW     = 2'h2;
  localparam logic [1:0]  CODE_HIGH    = 2'h3;
  localparam logic [1:0]  CODE_HIGHEST = 2'h1;
  localparam int          FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_FAST,
    MODE_HOLD,
    MODE_SLOW
  } tblsc_mode_t;

endpackage : tblsc_pkg

/* shared/tblsc_fifo_if.sv */
// Push and pop bundle between the slicer and its symbol FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tblsc_fifo_if #(parameter int W = 2);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;

  modport fifo (input wdata, wvalid, rready,
                output wready, rdata, rvalid);
  modport user (output wdata, wvalid, rready,
                input wready, rdata, rvalid);
endinterface : tblsc_fifo_if

/* logic/tblsc_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; depth a power of 2.
`timescale 1ns/10ps
module tblsc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input  wire logic   i_ref_clk,
  input  wire logic   i_reset_n,
  tblsc_fifo_if.fifo  q
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             push;
  logic             pop;

  assign q.wready = (count_ff != CW'(DEPTH));
  assign q.rvalid = (count_ff != '0);
  assign q.rdata  = mem_ff[rd_ptr_ff];
  assign push     = q.wvalid & q.wready;
  assign pop      = q.rvalid & q.rready;

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= q.wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  AST_FIFO_FULL_REFUSES: assert property (
    (count_ff == CW'(DEPTH)) |-> !q.wready)
    else $error("FIFO full but still ready");
  AST_FIFO_COUNT_STEP: assert property (
    (push && !pop) |=> (count_ff == $past(count_ff) + 1'b1))
    else $error("FIFO count did not follow a push");
endmodule : tblsc_fifo

/* logic/tblsc_slicer.sv */
// Two-bit level slicer control: mode decode, peak and valley tracking,
// Gray symbol coding into a FIFO, analog steering and AXI4-Lite registers.
// Assumes the symbol clock and all pins are synchronous to i_ref_clk.
`timescale 1ns/10ps
module tblsc_slicer (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_sym_clk,
  input  wire logic        i_mode_select_bit0,
  input  wire logic        i_mode_select_bit1,
  input  wire logic        i_track_inhibit,
  input  wire logic        i_filter_band_select,
  input  wire logic        i_supply_select,
  input  wire logic [7:0]  i_baseband_analog_in,
  input  wire logic        i_level_ready,
  output logic             o_level_code_bit0,
  output logic             o_level_code_bit1,
  output logic             o_level_valid,
  output logic             o_filter_wide_bw,
  output logic             o_charge_pump_en,
  output logic             o_gain_low_sel,
  output logic             o_standby,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic [2:0]  i_awprot,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic [2:0]  i_arprot,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  tblsc_fifo_if #(.W(tblsc_pkg::CODE_W)) fq ();

  logic                 sym_clk_d_ff;
  logic                 fall_en;
  logic                 trk_en_ff;
  tblsc_pkg::tblsc_mode_t mode_ff;
  logic [1:0]           mode_pins_ff;
  logic                 inhibit_ff;
  logic [7:0]           sample_ff;
  logic [7:0]           peak_ff;
  logic [7:0]           valley_ff;
  logic [7:0]           nxt_peak;
  logic [7:0]           nxt_valley;
  logic [5:0]           decay_cnt_ff;
  logic [5:0]           decay_period;
  logic                 decay_tick;
  logic [7:0]           step;
  logic [7:0]           span;
  logic [10:0]          span5;
  logic [8:0]           thr_lo;
  logic [8:0]           thr_mid;
  logic [8:0]           thr_hi;
  logic [1:0]           nxt_code;
  logic [1:0]           last_code_ff;
  logic                 sample_go;
  logic                 push;
  logic                 track_go;
  logic [31:0]          ctrl_ff;
  logic                 ovf_ff;
  logic [7:0]           awaddr_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 aw_got_ff;
  logic                 w_got_ff;
  logic                 wr_commit;
  logic                 ovf_clear;
  logic [31:0]          status_word;
  logic [31:0]          nxt_rdata;
  logic [1:0]           nxt_rresp;

  // ****************************************************************
  // Symbol clock falling edge and input latching
  // ****************************************************************
  assign fall_en = sym_clk_d_ff & !i_sym_clk;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      sym_clk_d_ff <= 1'b0;
      trk_en_ff    <= 1'b0;
    end else begin
      sym_clk_d_ff <= i_sym_clk;
      trk_en_ff    <= fall_en;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mode_ff          <= tblsc_pkg::MODE_STANDBY;
      mode_pins_ff     <= 2'h0;
      inhibit_ff       <= 1'b1;
      sample_ff        <= 8'h00;
      o_filter_wide_bw <= 1'b0;
    end else if (fall_en) begin
      mode_pins_ff     <= {i_mode_select_bit1, i_mode_select_bit0};
      unique case ({i_mode_select_bit0, i_mode_select_bit1})
        2'h0: mode_ff <= tblsc_pkg::MODE_STANDBY;
        2'h1: mode_ff <= tblsc_pkg::MODE_FAST;
        2'h2: mode_ff <= tblsc_pkg::MODE_HOLD;
        2'h3: mode_ff <= tblsc_pkg::MODE_SLOW;
      endcase
      inhibit_ff       <= i_track_inhibit;
      sample_ff        <= i_baseband_analog_in;
      o_filter_wide_bw <= i_filter_band_select;
    end
  end

  // Supply select acts one reference clock later, not on the symbol clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_charge_pump_en <= 1'b0;
      o_gain_low_sel   <= 1'b0;
      o_standby        <= 1'b1;
    end else begin
      o_charge_pump_en <= i_supply_select;
      o_gain_low_sel   <= i_supply_select;
      o_standby        <= (mode_ff == tblsc_pkg::MODE_STANDBY);
    end
  end

  // ****************************************************************
  // Peak and valley tracking
  // ****************************************************************
  assign sample_go = trk_en_ff & ctrl_ff[tblsc_pkg::CTRL_EN_BIT]
                   & (mode_ff != tblsc_pkg::MODE_STANDBY);
  assign push      = sample_go & fq.wready;
  assign track_go  = push & !inhibit_ff
                   & ((mode_ff == tblsc_pkg::MODE_FAST)
                   | (mode_ff == tblsc_pkg::MODE_SLOW));
  assign step = (mode_ff == tblsc_pkg::MODE_FAST) ? tblsc_pkg::STEP_FAST
                                                  : tblsc_pkg::STEP_SLOW;
  assign decay_period = (mode_ff == tblsc_pkg::MODE_FAST) ?
                        tblsc_pkg::DECAY_FAST : tblsc_pkg::DECAY_SLOW;
  assign decay_tick = (decay_cnt_ff >= decay_period);

  always_comb begin
    nxt_peak   = peak_ff;
    nxt_valley = valley_ff;
    if (track_go) begin
      if (sample_ff > peak_ff) begin
        nxt_peak = (sample_ff - peak_ff > step) ? peak_ff + step : sample_ff;
      end else if (decay_tick && peak_ff > valley_ff) begin
        nxt_peak = peak_ff - 8'h01;
      end
      if (sample_ff < valley_ff) begin
        nxt_valley = (valley_ff - sample_ff > step) ? valley_ff - step
                                                    : sample_ff;
      end else if (decay_tick && valley_ff < peak_ff) begin
        nxt_valley = valley_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      peak_ff      <= tblsc_pkg::LEVEL_RESET;
      valley_ff    <= tblsc_pkg::LEVEL_RESET;
      decay_cnt_ff <= 6'h00;
    end else if (track_go) begin
      peak_ff      <= nxt_peak;
      valley_ff    <= nxt_valley;
      decay_cnt_ff <= decay_tick ? 6'h00 : decay_cnt_ff + 6'h01;
    end
  end

  // ****************************************************************
  // Gray coding against the tracked span
  // ****************************************************************
  assign span    = (peak_ff > valley_ff) ? peak_ff - valley_ff : 8'h00;
  assign span5   = {3'h0, span} * tblsc_pkg::HI_NUM;
  assign thr_lo  = {1'b0, valley_ff}
                 + {1'b0, 8'(span / tblsc_pkg::SIXTH_DEN)};
  assign thr_mid = {1'b0, valley_ff} + {2'h0, span[7:1]};
  assign thr_hi  = {1'b0, valley_ff}
                 + {1'b0, 8'(span5 / tblsc_pkg::SIXTH_DEN)};

  always_comb begin
    if ({1'b0, sample_ff} >= thr_hi) begin
      nxt_code = tblsc_pkg::CODE_HIGHEST;
    end else if ({1'b0, sample_ff} >= thr_mid) begin
      nxt_code = tblsc_pkg::CODE_HIGH;
    end else if ({1'b0, sample_ff} >= thr_lo) begin
      nxt_code = tblsc_pkg::CODE_LOW;
    end else begin
      nxt_code = tblsc_pkg::CODE_LOWEST;
    end
  end

  assign fq.wdata  = nxt_code;
  assign fq.wvalid = sample_go;
  assign fq.rready = !o_level_valid | i_level_ready;

  tblsc_fifo #(
    .WIDTH (tblsc_pkg::CODE_W),
    .DEPTH (tblsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .q         (fq.fifo)
  );

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_level_code_bit0 <= 1'b0;
      o_level_code_bit1 <= 1'b0;
      o_level_valid     <= 1'b0;
    end else if (fq.rready) begin
      o_level_code_bit0 <= fq.rdata[0];
      o_level_code_bit1 <= fq.rdata[1];
      o_level_valid     <= fq.rvalid;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      last_code_ff <= tblsc_pkg::CODE_LOWEST;
    end else if (push) begin
      last_code_ff <= nxt_code;
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_commit = aw_got_ff & w_got_ff & !o_bvalid;
  assign ovf_clear = wr_commit & (awaddr_ff == tblsc_pkg::REG_STATUS)
                   & wstrb_ff[3] & wdata_ff[tblsc_pkg::ST_OVF_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= tblsc_pkg::RESP_OKAY;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (!o_awready && !aw_got_ff && !o_bvalid) begin
        o_awready <= 1'b1;
      end
      if (!o_wready && !w_got_ff && !o_bvalid) begin
        o_wready <= 1'b1;
      end
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      if (wr_commit) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (awaddr_ff == tblsc_pkg::REG_CTRL ||
                      awaddr_ff == tblsc_pkg::REG_STATUS) ?
                     tblsc_pkg::RESP_OKAY : tblsc_pkg::RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_ff <= tblsc_pkg::CTRL_RESET;
    end else if (wr_commit && awaddr_ff == tblsc_pkg::REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_ff[b]) begin
          ctrl_ff[b*8 +: 8] <= wdata_ff[b*8 +: 8];
        end
      end
    end
  end

  // Lost samples win over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ovf_ff <= 1'b0;
    end else if (sample_go && !fq.wready) begin
      ovf_ff <= 1'b1;
    end else if (ovf_clear) begin
      ovf_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[tblsc_pkg::ST_PEAK_LSB +: 8]   = peak_ff;
    status_word[tblsc_pkg::ST_VALLEY_LSB +: 8] = valley_ff;
    status_word[tblsc_pkg::ST_MODE_LSB +: 2]   = mode_pins_ff;
    status_word[tblsc_pkg::ST_INH_BIT]         = inhibit_ff;
    status_word[tblsc_pkg::ST_WIDE_BIT]        = o_filter_wide_bw;
    status_word[tblsc_pkg::ST_SUPPLY_BIT]      = o_charge_pump_en;
    status_word[tblsc_pkg::ST_CODE_LSB +: 2]   = last_code_ff;
    status_word[tblsc_pkg::ST_OVF_BIT]         = ovf_ff;
    nxt_rresp = tblsc_pkg::RESP_OKAY;
    unique case (i_araddr)
      tblsc_pkg::REG_CTRL:   nxt_rdata = ctrl_ff;
      tblsc_pkg::REG_STATUS: nxt_rdata = status_word;
      default: begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = tblsc_pkg::RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= tblsc_pkg::RESP_OKAY;
    end else begin
      if (!o_arready && !o_rvalid) begin
        o_arready <= 1'b1;
      end
      if (o_arready && i_arvalid) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= nxt_rdata;
        o_rresp   <= nxt_rresp;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_sample_step;
    fall_en ##1 trk_en_ff;
  endsequence

  AST_MODE_DECODE: assert property (
    fall_en && !i_mode_select_bit0 && i_mode_select_bit1
    |=> mode_ff == tblsc_pkg::MODE_FAST)
    else $error("Mode pins 0 and 1 did not select fast track");
  AST_RUN_STEP: assert property (
    track_go && mode_ff == tblsc_pkg::MODE_FAST
    && sample_ff > peak_ff + 8'h04 && peak_ff < 8'hF0
    |=> peak_ff == $past(peak_ff) + 8'h04)
    else $error("Fast track peak did not step by four");
  AST_INHIBIT_FREEZE: assert property (
    s_sample_step ##0 inhibit_ff |=> $stable(peak_ff) && $stable(valley_ff))
    else $error("Levels moved while tracking inhibited");
  AST_INHIBIT_LATCH: assert property (
    !fall_en |=> $stable(inhibit_ff))
    else $error("Track inhibit changed off the falling edge");
  AST_BAND_LATCH: assert property (
    fall_en ##1 !fall_en[*3]
    |-> o_filter_wide_bw == $past(i_filter_band_select, 3))
    else $error("Band select not held from the falling edge");
  AST_PUMP_GAIN: assert property (
    $past(i_reset_n) |-> o_charge_pump_en == o_gain_low_sel
    && o_charge_pump_en == $past(i_supply_select))
    else $error("Charge pump or gain does not follow supply select");
  AST_TOP_CODE: assert property (
    push && peak_ff >= valley_ff && sample_ff >= peak_ff
    |-> fq.wdata == tblsc_pkg::CODE_HIGHEST)
    else $error("Sample at peak not coded as highest level");
  AST_BOTTOM_CODE: assert property (
    push && peak_ff > valley_ff + 8'h06 && sample_ff < valley_ff
    |-> fq.wdata == tblsc_pkg::CODE_LOWEST)
    else $error("Sample below valley not coded as lowest level");
  AST_HOLD_FROZEN: assert property (
    s_sample_step ##0 mode_ff == tblsc_pkg::MODE_HOLD
    |=> $stable(peak_ff) && $stable(valley_ff))
    else $error("Levels moved in hold mode");
  AST_STANDBY_SILENT: assert property (
    mode_ff == tblsc_pkg::MODE_STANDBY |-> !push)
    else $error("Symbol pushed in standby");
  AST_WRITE_ANSWER: assert property (
    wr_commit |=> o_bvalid ##0 !aw_got_ff)
    else $error("Write response missing after commit");
endmodule : tblsc_slicer

/* verification/tblsc_decoder_model.sv */
// Decoder-side model: makes the symbol clock and takes symbols.
// Assumes a 40 MHz reference clock and a synchronous active-low reset.
`timescale 1ns/10ps
module tblsc_decoder_model #(
  parameter int HALF = 521
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_stall,
  input  wire logic       i_level_valid,
  input  wire logic [1:0] i_code,
  output logic            o_sym_clk,
  output logic            o_level_ready,
  output logic            o_got,
  output logic [1:0]      o_code,
  output int              o_count
);
  int half_ff;

  // Even duty, close to 38.4 kHz
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      half_ff <= 0;
      o_sym_clk <= 1'h1;
    end else if (half_ff == HALF - 1) begin
      half_ff <= 0;
      o_sym_clk <= ~o_sym_clk;
    end else begin
      half_ff <= half_ff + 1;
    end
  end

  // Random back-pressure, full stall on request
  always_ff @(posedge i_ref_clk) begin
    o_level_ready <= i_reset_n && !i_stall && ($urandom % 4 != 0);
    o_got <= i_level_valid && o_level_ready;
    o_code <= i_code;
    if (!i_reset_n) o_count <= 0;
    else if (i_level_valid && o_level_ready) o_count <= o_count + 1;
  end
endmodule : tblsc_decoder_model

/* verification/two_bit_level_slicer_control_bench.sv */
// Self-checking bench of the slicer control and its symbol FIFO.
// Assumes the package, FIFO interface and design compiled before it.
`timescale 1ns/10ps
module two_bit_level_slicer_control_bench;
  logic i_ref_clk = 0, i_reset_n = 0, i_sym_clk, i_level_ready, got;
  logic i_mode_select_bit0 = 0, i_mode_select_bit1 = 0, stall = 0;
  logic i_track_inhibit = 0, i_filter_band_select = 0, i_supply_select = 0;
  logic [7:0] i_baseband_analog_in = 0, i_awaddr = 0, i_araddr = 0;
  logic [2:0] i_awprot = 0, i_arprot = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
  logic i_rready = 0, o_level_code_bit0, o_level_code_bit1, o_level_valid;
  logic o_filter_wide_bw, o_charge_pump_en, o_gain_low_sel, o_standby;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] o_bresp, o_rresp, gcode;
  int n_mismatch = 0, n_compared = 0, cyc = 0, cnt, count;

  always #12.5 i_ref_clk = ~i_ref_clk;

  tblsc_slicer tblsc_slicer_i (.*);
  tblsc_decoder_model tblsc_decoder_model_i (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_stall(stall),
    .i_level_valid(o_level_valid),
    .i_code({o_level_code_bit1, o_level_code_bit0}),
    .o_sym_clk(i_sym_clk), .o_level_ready(i_level_ready),
    .o_got(got), .o_code(gcode), .o_count(count));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (!o_bvalid);
    r = o_bresp;
    i_bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do begin
      @(posedge i_ref_clk);
      if (o_arready) i_arvalid <= 0;
    end while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 0;
  endtask : rd

  task automatic fall(input int n);
    repeat (n) begin
      @(negedge i_sym_clk);
      @(posedge i_ref_clk);
    end
  endtask : fall

  task automatic take(input logic [1:0] e);
    cnt = 0;
    do @(posedge i_ref_clk); while (!got && ++cnt < 60);
    chk(32'(got), 1);
    chk(32'(gcode), 32'(e));
  endtask : take

  // No symbol may reach the decoder
  task automatic quiet();
    int c0;
    fall(1);
    c0 = count;
    fall(2);
    chk(count, c0);
  endtask : quiet

  function automatic logic [1:0] expc(input int s, input int p, input int v);
    int sp;
    sp = (p > v) ? p - v : 0;
    if (s >= v + sp * 5 / 6) return 2'h1;
    if (s >= v + sp / 2) return 2'h3;
    if (s >= v + sp / 6) return 2'h2;
    return 2'h0;
  endfunction : expc

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    logic [31:0] d, e;
    logic [1:0] r;
    int p, v, s, c0;
    int cs[4];
    void'($urandom(32'h8669));
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1;
    rd(tblsc_pkg::REG_CTRL, d, r);
    chk(d, tblsc_pkg::CTRL_RESET);
    chk(32'(o_standby), 1);
    rd(tblsc_pkg::REG_STATUS, d, r);
    chk(32'(d[15:0]), {16'h0, {2{tblsc_pkg::LEVEL_RESET}}});
    rd(8'hFC, d, r);
    chk(32'(r), 32'(tblsc_pkg::RESP_SLVERR));
    wr(8'hFC, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'(tblsc_pkg::RESP_SLVERR));
    for (int m = 0; m < 4; m++) begin
      {i_mode_select_bit1, i_mode_select_bit0} <= {m[1], m[0]};
      i_filter_band_select <= 1'($urandom);
      i_supply_select <= 1'($urandom);
      fall(1);
      repeat (2) @(posedge i_ref_clk);
      chk(32'(o_charge_pump_en), 32'(i_supply_select));
      chk(32'(o_gain_low_sel), 32'(i_supply_select));
      chk(32'(o_filter_wide_bw), 32'(i_filter_band_select));
      chk(32'(o_standby), 32'(m == 0));
      rd(tblsc_pkg::REG_STATUS, d, r);
      chk(32'(d[17:16]), 32'({m[1], m[0]}));
    end
    i_supply_select <= ~i_supply_select;
    repeat (3) @(posedge i_ref_clk);
    chk(32'(o_charge_pump_en), 32'(i_supply_select));
    {i_mode_select_bit1, i_mode_select_bit0} <= 2'h2;
    for (int i = 0; i < 16; i++) begin
      i_baseband_analog_in <= i[0] ? 8'h10 : 8'hF0;
      fall(1);
    end
    rd(tblsc_pkg::REG_STATUS, d, r);
    chk(32'(d[7:0] > 8'h80 && d[15:8] < 8'h80), 1);
    i_track_inhibit <= 1;
    fall(2);
    rd(tblsc_pkg::REG_STATUS, d, r);
    fall(3);
    rd(tblsc_pkg::REG_STATUS, e, r);
    chk(32'(e[15:0]), 32'(d[15:0]));
    i_track_inhibit <= 0;
    {i_mode_select_bit1, i_mode_select_bit0} <= 2'h1;
    fall(2);
    rd(tblsc_pkg::REG_STATUS, d, r);
    p = d[7:0];
    v = d[15:8];
    cs = '{v + (p - v) / 6, v + (p - v) / 2, v + (p - v) * 5 / 6, v - 1};
    for (int i = 0; i < 20; i++) begin
      s = i < 4 ? cs[i] : v - 8 + int'($urandom % 32'(p - v + 17));
      i_baseband_analog_in <= 8'(s);
      fall(1);
      take(expc(s, p, v));
    end
    rd(tblsc_pkg::REG_STATUS, e, r);
    chk(32'(e[15:0]), 32'(d[15:0]));
    wr(tblsc_pkg::REG_CTRL, 32'h0, r);
    quiet();
    wr(tblsc_pkg::REG_CTRL, 32'h1, r);
    stall <= 1;
    fall(12);
    rd(tblsc_pkg::REG_STATUS, d, r);
    chk(32'(d[tblsc_pkg::ST_OVF_BIT]), 1);
    wr(tblsc_pkg::REG_STATUS, 32'h0100_0000, r);
    rd(tblsc_pkg::REG_STATUS, d, r);
    chk(32'(d[tblsc_pkg::ST_OVF_BIT]), 0);
    c0 = count;
    stall <= 0;
    repeat (60) @(posedge i_ref_clk);
    chk(count - c0, tblsc_pkg::FIFO_DEPTH + 1);
    {i_mode_select_bit1, i_mode_select_bit0} <= 2'h0;
    fall(1);
    quiet();
    conclude();
  end
endmodule : two_bit_level_slicer_control_bench
